// file: lsag_core.sv
// load/store address generation, sequencing and write-back
`timescale 1ns/100ps
module lsag_core
  import lsag_pkg::*;
#(
  parameter int REG_IDX_W = 4
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic op_load,
  input wire lsag_mode_t op_mode,
  input wire lsag_size_t op_size,
  input wire logic op_signed,
  input wire logic op_pair,
  input wire logic op_unpriv,
  input wire logic cpu_privileged,
  input wire logic op_imm_add,
  input wire logic [12:0] op_imm_mag,
  input wire logic [1:0] op_shift,
  input wire logic [REG_IDX_W-1:0] op_rt,
  input wire logic [REG_IDX_W-1:0] op_rt2,
  input wire logic [REG_IDX_W-1:0] op_rn,
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_val,
  input wire logic [31:0] pc_val,
  input wire logic [31:0] rt_val,
  input wire logic [31:0] rt2_val,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output lsag_size_t mem_size,
  output logic [31:0] mem_wdata,
  output logic mem_unpriv,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic wb_we,
  output logic [REG_IDX_W-1:0] wb_idx,
  output logic [31:0] wb_data,
  output logic base_we,
  output logic [REG_IDX_W-1:0] base_idx,
  output logic [31:0] base_data,
  output logic branch_valid,
  output logic [31:0] branch_target,
  output logic op_done,
  output logic op_fault,
  output logic flags_we
);
  if (REG_IDX_W != 4)
  begin : g_chk
    $error("lsag_core needs REG_IDX_W of 4");
  end

  lsag_state_t state_r;
  logic ready_r, req_r, write_r, unpriv_r, ld_r, sgn_r, pair_r, wbk_r;
  lsag_size_t size_r;
  lsag_mode_t mode_r;
  logic [31:0] addr_r, wdata_r, rt2_val_r, wbk_val_r, first_addr_r;
  logic [REG_IDX_W-1:0] rt_r, rt2_r, rn_r;
  logic wb_we_r, base_we_r, branch_r, done_r, fault_r, flags_r;
  logic [REG_IDX_W-1:0] wb_idx_r, base_idx_r;
  logic [31:0] wb_data_r, base_data_r, target_r;
  logic [31:0] off32, base_sel, ea_sum, acc_addr, ext_data;
  logic legal, take, bad, last_ack, to_pc;

  // ****************
  // address and range checks
  // ****************
  function automatic logic ofs_ok(lsag_mode_t m, logic pr, logic up, logic ad, logic [12:0] mg);
    logic ok;
    ok = 1'b0;
    if (pr)
      ok = (m != MODE_REG) && !up && (mg <= OFS_MAX_PAIR) && (mg[1:0] == 2'h0);
    else if (up)
      ok = (m == MODE_OFFSET) && ad && (mg <= OFS_MAX_NARROW);
    else
      case (m)
        MODE_OFFSET: ok = ad ? (mg <= OFS_MAX_WIDE) : (mg <= OFS_MAX_NARROW);
        MODE_PRE, MODE_POST: ok = (mg <= OFS_MAX_NARROW);
        MODE_PCREL: ok = (mg <= OFS_MAX_WIDE);
        MODE_REG: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    return ok;
  endfunction

  always_comb
  begin
    off32 = {19'h0, op_imm_mag};
    base_sel = (op_mode == MODE_PCREL) ? pc_val : base_val;
    if (op_mode == MODE_REG)
      ea_sum = base_val + (index_val << op_shift);
    else if (op_imm_add)
      ea_sum = base_sel + off32;
    else
      ea_sum = base_sel - off32;
    acc_addr = (op_mode == MODE_POST) ? base_val : ea_sum;
  end

  assign legal = ofs_ok(op_mode, op_pair, op_unpriv, op_imm_add, op_imm_mag);
  assign take = op_valid && ready_r && legal;
  assign bad = op_valid && ready_r && !legal;
  assign last_ack = mem_ack && ((state_r == ST_ACC1 && !pair_r) || state_r == ST_ACC2);
  assign to_pc = (state_r == ST_ACC1) && ld_r && !pair_r && (size_r == SZ_WORD)
    && (rt_r == PC_IDX);

  lsag_ext u_ext (
    .raw(mem_rdata),
    .size(size_r),
    .sgn(sgn_r),
    .ext(ext_data)
  );

  // ****************
  // sequencing
  // ****************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (take)
          begin
            state_r <= ST_ACC1;
            ready_r <= 1'b0;
          end
        ST_ACC1:
          if (mem_ack)
          begin
            state_r <= pair_r ? ST_ACC2 : ST_IDLE;
            ready_r <= !pair_r;
          end
        ST_ACC2:
          if (mem_ack)
          begin
            state_r <= ST_IDLE;
            ready_r <= 1'b1;
          end
        default:
        begin
          state_r <= ST_IDLE;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  // ****************
  // operation context
  // ****************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ld_r <= 1'b0;
      sgn_r <= 1'b0;
      pair_r <= 1'b0;
      wbk_r <= 1'b0;
      size_r <= SZ_WORD;
      mode_r <= MODE_OFFSET;
      rt_r <= '0;
      rt2_r <= '0;
      rn_r <= '0;
      rt2_val_r <= ZERO_WORD;
      wbk_val_r <= ZERO_WORD;
      first_addr_r <= ZERO_WORD;
    end
    else if (take)
    begin
      ld_r <= op_load;
      sgn_r <= op_signed && op_load;
      pair_r <= op_pair;
      wbk_r <= (op_mode == MODE_PRE) || (op_mode == MODE_POST);
      size_r <= op_pair ? SZ_WORD : op_size;
      mode_r <= op_mode;
      rt_r <= op_rt;
      rt2_r <= op_rt2;
      rn_r <= op_rn;
      rt2_val_r <= rt2_val;
      wbk_val_r <= ea_sum;
      first_addr_r <= acc_addr;
    end
  end

  // ****************
  // memory request
  // ****************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_r <= 1'b0;
      addr_r <= ZERO_WORD;
      write_r <= 1'b0;
      wdata_r <= ZERO_WORD;
      unpriv_r <= 1'b0;
    end
    else if (take)
    begin
      req_r <= 1'b1;
      addr_r <= acc_addr;
      write_r <= !op_load;
      wdata_r <= rt_val;
      unpriv_r <= op_unpriv || !cpu_privileged;
    end
    else if (state_r == ST_ACC1 && mem_ack && pair_r)
    begin
      addr_r <= addr_r + PAIR_STEP;
      wdata_r <= rt2_val_r;
    end
    else if (last_ack)
      req_r <= 1'b0;
  end

  // ****************
  // write-back and retirement
  // ****************
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_we_r <= 1'b0;
      wb_idx_r <= '0;
      wb_data_r <= ZERO_WORD;
      base_we_r <= 1'b0;
      base_idx_r <= '0;
      base_data_r <= ZERO_WORD;
      branch_r <= 1'b0;
      target_r <= ZERO_WORD;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      flags_r <= 1'b0;
    end
    else
    begin
      wb_we_r <= mem_ack && ld_r && (state_r != ST_IDLE) && !to_pc;
      wb_idx_r <= (state_r == ST_ACC2) ? rt2_r : rt_r;
      wb_data_r <= ext_data;
      branch_r <= mem_ack && to_pc;
      target_r <= {ext_data[31:1], 1'b0};
      base_we_r <= last_ack && wbk_r;
      base_idx_r <= rn_r;
      base_data_r <= wbk_val_r;
      done_r <= last_ack;
      fault_r <= bad;
      flags_r <= 1'b0;
    end
  end

  assign op_ready = ready_r;
  assign mem_req = req_r;
  assign mem_addr = addr_r;
  assign mem_write = write_r;
  assign mem_size = size_r;
  assign mem_wdata = wdata_r;
  assign mem_unpriv = unpriv_r;
  assign wb_we = wb_we_r;
  assign wb_idx = wb_idx_r;
  assign wb_data = wb_data_r;
  assign base_we = base_we_r;
  assign base_idx = base_idx_r;
  assign base_data = base_data_r;
  assign branch_valid = branch_r;
  assign branch_target = target_r;
  assign op_done = done_r;
  assign op_fault = fault_r;
  assign flags_we = flags_r;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_take(lsag_mode_t m);
    take && op_mode == m;
  endsequence
  sequence s_retire;
    op_done && base_we;
  endsequence

  a_offset_addr: assert property (s_take(MODE_OFFSET) |=> mem_req && mem_addr == $past(ea_sum)) else $error("offset address wrong");
  a_offset_keep: assert property (op_done && mode_r == MODE_OFFSET |-> !base_we) else $error("offset mode wrote base");
  a_pre_wb: assert property (op_done && mode_r == MODE_PRE |-> s_retire and base_data == first_addr_r) else $error("pre-index write-back wrong");
  a_post_addr: assert property (s_take(MODE_POST) |=> mem_addr == $past(base_val)) else $error("post-index address wrong");
  a_reg_shift: assert property (s_take(MODE_REG) |=> mem_addr == $past(base_val + (index_val << op_shift))) else $error("register offset address wrong");
  a_range_fault: assert property (op_valid && op_ready && !legal |=> op_fault && !mem_req) else $error("illegal offset accepted");
  a_pair_step: assert property (state_r == ST_ACC1 && mem_ack && pair_r |=> mem_req && mem_addr == $past(mem_addr) + PAIR_STEP) else $error("pair second address wrong");
  a_pc_branch: assert property (branch_valid |-> !branch_target[0] && !wb_we && $past(mem_ack)) else $error("pc load branch wrong");
  a_unpriv_mark: assert property (take && (op_unpriv || !cpu_privileged) |=> mem_unpriv) else $error("unprivileged mark missing");
  a_sign_byte: assert property (wb_we && sgn_r && size_r == SZ_BYTE |-> wb_data[31:8] == {24{wb_data[7]}}) else $error("byte sign extension wrong");
  a_wb_retire: assert property (base_we |-> op_done && $past(mem_ack)) else $error("base write-back not at retirement");
  a_flags_still: assert property (op_valid |=> !flags_we ##1 !flags_we) else $error("flags written");
  a_no_hang: assert property (mem_req && mem_ack && state_r == ST_ACC2 |=> op_ready) else $error("sequencer stuck");
endmodule

// file: lsag_core_bench.sv
// self-checking bench for the load/store address generator
`timescale 1ns/100ps
module lsag_core_bench;
  import lsag_pkg::*;
  localparam logic [31:0] KEY = 32'hC3C3_8181;
  logic mclk, arst_n, op_valid, op_ready, op_load, op_signed, op_pair, op_unpriv;
  logic cpu_privileged, op_imm_add, mem_req, mem_write, mem_unpriv, mem_ack, wb_we, base_we;
  logic branch_valid, op_done, op_fault, flags_we, up, dn, wr;
  logic [1:0] szc;
  lsag_mode_t op_mode;
  lsag_size_t op_size, mem_size;
  logic [12:0] op_imm_mag;
  logic [1:0] op_shift;
  logic [3:0] op_rt, op_rt2, op_rn, wb_idx, base_idx, lat, bi;
  logic [3:0] iq[$];
  logic [31:0] base_val, index_val, pc_val, rt_val, rt2_val, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] wb_data, base_data, branch_target;
  logic [31:0] aq[$], wq[$], bq[$], brq[$], dq[$];
  int mismatches = 0;
  int checked = 0;
  int flt;

  lsag_core #(.REG_IDX_W(4)) dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .op_valid(op_valid),
    .op_ready(op_ready),
    .op_load(op_load),
    .op_mode(op_mode),
    .op_size(op_size),
    .op_signed(op_signed),
    .op_pair(op_pair),
    .op_unpriv(op_unpriv),
    .cpu_privileged(cpu_privileged),
    .op_imm_add(op_imm_add),
    .op_imm_mag(op_imm_mag),
    .op_shift(op_shift),
    .op_rt(op_rt),
    .op_rt2(op_rt2),
    .op_rn(op_rn),
    .base_val(base_val),
    .index_val(index_val),
    .pc_val(pc_val),
    .rt_val(rt_val),
    .rt2_val(rt2_val),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_write(mem_write),
    .mem_size(mem_size),
    .mem_wdata(mem_wdata),
    .mem_unpriv(mem_unpriv),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .wb_we(wb_we),
    .wb_idx(wb_idx),
    .wb_data(wb_data),
    .base_we(base_we),
    .base_idx(base_idx),
    .base_data(base_data),
    .branch_valid(branch_valid),
    .branch_target(branch_target),
    .op_done(op_done),
    .op_fault(op_fault),
    .flags_we(flags_we)
  );
  lsag_mem_model #(.KEY(KEY)) mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .lat(lat),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  always #4 mclk = ~mclk;

  // ************
  // monitor
  // ************
  always @(posedge mclk)
  begin
    if (mem_req && mem_ack)
    begin
      aq.push_back(mem_addr);
      dq.push_back(mem_wdata);
      up = mem_unpriv;
      wr = mem_write;
      szc = mem_size;
    end
    if (wb_we) wq.push_back(wb_data);
    if (wb_we) iq.push_back(wb_idx);
    if (base_we) bq.push_back(base_data);
    if (base_we) bi = base_idx;
    if (branch_valid) brq.push_back(branch_target);
    if (op_fault) flt++;
    if (op_done || op_fault) dn = 1'b1;
    if (arst_n) chk(32'(flags_we), 32'h0);
  end

  // ************
  // helpers
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic set(input logic ld, input lsag_mode_t md, input lsag_size_t sz, input logic sg,
                     input logic pr, input logic ad, input logic [12:0] mg);
    op_load = ld;
    op_mode = md;
    op_size = sz;
    op_signed = sg;
    op_pair = pr;
    op_imm_add = ad;
    op_imm_mag = mg;
  endtask

  task automatic go();
    aq.delete();
    wq.delete();
    bq.delete();
    brq.delete();
    dq.delete();
    iq.delete();
    {up, wr, szc, bi} = 'x;
    flt = 0;
    dn = 1'b0;
    op_valid = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
    for (int i = 0; i < 40 && !dn; i++)
      @(negedge mclk);
    if (!dn)
    begin
      mismatches++;
      $display("ERROR t=%0t operation hung", $time);
      wrap_up();
    end
  endtask

  // ************
  // scenarios
  // ************
  task automatic s_offset();
    set(1'b1, MODE_OFFSET, SZ_WORD, 1'b0, 1'b0, 1'b1, 13'h0FFF);
    go();
    chk(aq[0], 32'h0000_1FFF);
    chk(wq[0], 32'h0000_1FFF ^ KEY);
    chk(32'(bq.size()), 32'h0);
    chk(32'(wr), 32'h0);
    chk(32'(up), 32'h0);
    chk(32'(szc), 32'(SZ_WORD));
    chk(32'(iq[0]), 32'h1);
  endtask

  task automatic s_pre();
    lat = 4'h3;
    set(1'b0, MODE_PRE, SZ_WORD, 1'b0, 1'b0, 1'b0, 13'h00FF);
    go();
    chk(aq[0], 32'h0000_0F01);
    chk(bq[0], 32'h0000_0F01);
    chk(32'(wq.size()), 32'h0);
    chk(32'(wr), 32'h1);
    chk(dq[0], 32'h1234_5678);
    chk(32'(bi), 32'h3);
    lat = 4'h0;
  endtask

  task automatic s_post();
    set(1'b1, MODE_POST, SZ_BYTE, 1'b0, 1'b0, 1'b1, 13'h00FF);
    go();
    chk(aq[0], 32'h0000_1000);
    chk(bq[0], 32'h0000_10FF);
    chk(wq[0], 32'h0000_0081);
    chk(32'(szc), 32'(SZ_BYTE));
  endtask

  task automatic s_ext();
    lsag_size_t sz[4] = '{SZ_BYTE, SZ_HALF, SZ_HALF, SZ_WORD};
    logic [31:0] ex[4] = '{32'hFFFF_FF81, 32'h0000_9181, 32'hFFFF_9181, 32'hC3C3_9181};
    for (int i = 0; i < 4; i++)
    begin
      set(1'b1, MODE_OFFSET, sz[i], !i[0], 1'b0, 1'b1, 13'h0000);
      go();
      chk(wq[0], ex[i]);
    end
  endtask

  task automatic s_pair();
    lat = 4'h2;
    set(1'b1, MODE_PRE, SZ_WORD, 1'b0, 1'b1, 1'b1, 13'h03FC);
    go();
    chk(aq[0], 32'h0000_13FC);
    chk(aq[1], 32'h0000_1400);
    chk(wq[0], 32'h0000_13FC ^ KEY);
    chk(wq[1], 32'h0000_1400 ^ KEY);
    chk(bq[0], 32'h0000_13FC);
    chk(32'(iq[0]), 32'h1);
    chk(32'(iq[1]), 32'h2);
    set(1'b0, MODE_POST, SZ_WORD, 1'b0, 1'b1, 1'b0, 13'h03FC);
    go();
    chk(aq[0], 32'h0000_1000);
    chk(aq[1], 32'h0000_1004);
    chk(dq[0], 32'h1234_5678);
    chk(dq[1], 32'h9ABC_DEF0);
    chk(bq[0], 32'h0000_0C04);
    lat = 4'h0;
  endtask

  task automatic s_refuse();
    lsag_mode_t md[7] = '{MODE_OFFSET, MODE_OFFSET, MODE_PRE, MODE_POST, MODE_PRE,
                          MODE_OFFSET, MODE_PCREL};
    logic [12:0] mg[7] = '{13'h1000, 13'h0100, 13'h0100, 13'h0100, 13'h03FA, 13'h0100, 13'h1000};
    logic [6:0] ad = 7'b1110101;
    for (int i = 0; i < 7; i++)
    begin
      set(1'b1, md[i], SZ_WORD, 1'b0, i == 4, ad[i], mg[i]);
      op_unpriv = (i == 5);
      go();
      chk(32'(flt), 32'h1);
      chk(32'(aq.size()), 32'h0);
    end
    op_unpriv = 1'b0;
  endtask

  task automatic s_reg();
    for (int s = 0; s < 4; s++)
    begin
      op_shift = s[1:0];
      set(1'b0, MODE_REG, SZ_WORD, 1'b0, 1'b0, 1'b1, 13'h0000);
      go();
      chk(aq[0], 32'h0000_1000 + (32'h0000_0010 << s));
    end
  endtask

  task automatic s_unpriv();
    op_unpriv = 1'b1;
    set(1'b0, MODE_OFFSET, SZ_WORD, 1'b0, 1'b0, 1'b1, 13'h00FF);
    go();
    chk(aq[0], 32'h0000_10FF);
    chk(32'(up), 32'h1);
    cpu_privileged = 1'b0;
    go();
    chk(aq[0], 32'h0000_10FF);
    chk(32'(up), 32'h1);
    op_unpriv = 1'b0;
    cpu_privileged = 1'b1;
  endtask

  task automatic s_pc();
    op_rt = 4'hF;
    set(1'b1, MODE_PCREL, SZ_WORD, 1'b0, 1'b0, 1'b1, 13'h0FFE);
    go(); // unconditional load to pc
    chk(aq[0], 32'h0000_2FFE);
    chk(brq[0], 32'hC3C3_AE7E);
    chk(32'(wq.size()), 32'h0);
    op_rt = 4'h1;
    set(1'b1, MODE_PCREL, SZ_WORD, 1'b0, 1'b0, 1'b0, 13'h0FFF);
    go();
    chk(aq[0], 32'h0000_1001);
    set(1'b1, MODE_PCREL, SZ_WORD, 1'b0, 1'b1, 1'b0, 13'h03FC);
    go();
    chk(aq[0], 32'h0000_1C04);
    chk(aq[1], 32'h0000_1C08);
  endtask

  task automatic s_reset();
    lat = 4'h8;
    set(1'b1, MODE_OFFSET, SZ_WORD, 1'b0, 1'b0, 1'b1, 13'h0004);
    op_valid = 1'b1;
    @(negedge mclk);
    op_valid = 1'b0;
    @(negedge mclk);
    chk(32'(op_ready), 32'h0);
    chk(32'(mem_req), 32'h1);
    arst_n = 1'b0;
    @(negedge mclk);
    chk(32'(op_ready), 32'h1);
    chk(32'(mem_req), 32'h0);
    chk(32'(op_done), 32'h0);
    arst_n = 1'b1;
    lat = 4'h0;
    go();
    chk(aq[0], 32'h0000_1004);
    chk(32'(wq.size()), 32'h1);
  endtask

  // ************
  // main sequence
  // ************
  initial
  begin
    mclk = 1'b0;
    arst_n = 1'b0;
    op_valid = 1'b0;
    op_unpriv = 1'b0;
    cpu_privileged = 1'b1;
    op_shift = 2'h0;
    lat = 4'h0;
    // rn apart from rt and rt2, no sp or pc stored
    op_rt = 4'h1;
    op_rt2 = 4'h2;
    op_rn = 4'h3;
    base_val = 32'h0000_1000;
    index_val = 32'h0000_0010;
    pc_val = 32'h0000_2000;
    rt_val = 32'h1234_5678;
    rt2_val = 32'h9ABC_DEF0;
    set(1'b1, MODE_OFFSET, SZ_WORD, 1'b0, 1'b0, 1'b1, 13'h0000);
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    s_offset();
    s_pre();
    s_post();
    s_ext();
    s_pair();
    s_refuse();
    s_reg();
    s_unpriv();
    s_pc();
    s_reset();
    wrap_up();
  end
endmodule

// file: lsag_ext.sv
// load data extension to a full word
`timescale 1ns/100ps
module lsag_ext
  import lsag_pkg::*;
(
  input wire logic [31:0] raw,
  input wire lsag_size_t size,
  input wire logic sgn,
  output logic [31:0] ext
);
  // ****************
  // extension
  // ****************
  always_comb
  begin
    case (size)
      SZ_BYTE: ext = {{24{sgn & raw[7]}}, raw[7:0]};
      SZ_HALF: ext = {{16{sgn & raw[15]}}, raw[15:0]};
      default: ext = raw;
    endcase
  end
endmodule

// file: lsag_mem_model.sv
// memory-side partner for the load/store address generator
`timescale 1ns/100ps
module lsag_mem_model
#(
  parameter logic [31:0] KEY = 32'hC3C3_8181
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt_r;

  // ack after lat idle cycles; data scrambled from the address
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end
    else if (mem_req && !mem_ack && cnt_r >= lat)
    begin
      cnt_r <= 4'h0;
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr ^ KEY;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// file: lsag_pkg.sv
// constants and types for the load/store address generator
// How it works
// - offset mode: address is base plus/minus immediate, base untouched
// - pre-indexed: address is base plus/minus offset, also written to base
// - post-indexed: access at base, then base plus/minus offset written back
// - immediate forms move byte, halfword, word or pair; loads signed or unsigned
// - single immediate: -255..4095 offset mode, -255..255 pre/post modes
// - pair immediate: multiples of four from -1020 to 1020, all modes
// - word load to program counter branches with bit zero cleared
// - register offset: base plus index shifted left zero to three
// - loads zero- or sign-extend bytes and halfwords to 32 bits
// - unprivileged variants mark access unprivileged; offsets 0..255 only
// - unprivileged variants in unprivileged state act as plain offset ops
// - pc-relative: -4095..4095 single, -1020..1020 pair
// - pc-relative load reads one register or pair at pc plus offset
// - no operation here modifies the condition flags
// - pair moves first register at address, second four bytes higher
package lsag_pkg;
  localparam int XLEN = 32;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [12:0] OFS_MAX_WIDE = 13'h0FFF;
  localparam logic [12:0] OFS_MAX_NARROW = 13'h00FF;
  localparam logic [12:0] OFS_MAX_PAIR = 13'h03FC;
  localparam logic [31:0] PAIR_STEP = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {MODE_OFFSET, MODE_PRE, MODE_POST, MODE_REG, MODE_PCREL} lsag_mode_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} lsag_size_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACC1, ST_ACC2} lsag_state_t;
endpackage
